/* pcr_pkg.sv */
// Package for the peripheral configuration register block.
// Assumes a 20 MHz system clock and an APB register bus with 32-bit data.
package pcr_pkg;

    // Register map. The printed offset is not a multiple of four, so it is an index.
    localparam logic [7:0] PCR_IDX_CONFIG_ONE = 8'hAA;
    localparam logic [11:0] PCR_ADDR_CONFIG_ONE = {2'h0, PCR_IDX_CONFIG_ONE, 2'h0};
    localparam logic [31:0] PCR_RESET_CONFIG_ONE = 32'h40000000;
    localparam logic [11:0] PCR_ADDR_STATUS = 12'h2AC;

    // Field positions.
    localparam int PCR_POS_PARITY = 31;
    localparam int PCR_POS_SS_OFF = 30;
    localparam int PCR_POS_ILIM_LO = 22;
    localparam int PCR_POS_ILIM_EN = 21;
    localparam int PCR_POS_DIR_LO = 19;
    localparam int PCR_POS_DIR_MODE = 18;
    localparam int PCR_POS_SELFCHK = 17;
    localparam int PCR_POS_GAP_LO = 13;
    localparam int PCR_POS_MOD_LO = 10;
    localparam int PCR_POS_RANGE = 9;
    localparam int PCR_POS_ALARM_OFF = 8;

    // Direction override codes.
    localparam logic [1:0] PCR_DIR_PIN_A = 2'h0;
    localparam logic [1:0] PCR_DIR_FORCE_CW = 2'h1;
    localparam logic [1:0] PCR_DIR_FORCE_CCW = 2'h2;
    localparam logic [1:0] PCR_DIR_PIN_B = 2'h3;

    // Reserved speed gap code and the code it is treated as.
    localparam logic [3:0] PCR_GAP_RESERVED = 4'hE;
    localparam logic [3:0] PCR_GAP_FULL = 4'hF;

    // Bus current limit in mA per code.
    localparam logic [15:0] PCR_ILIM_MA [16] = '{
        16'd125, 16'd250, 16'd500, 16'd1000, 16'd1500, 16'd2000, 16'd2500, 16'd3000,
        16'd3500, 16'd4000, 16'd4500, 16'd5000, 16'd5500, 16'd6000, 16'd7000, 16'd8000};

    // Speed gap threshold in tenths of a percent per code.
    localparam logic [9:0] PCR_GAP_PERMILLE [16] = '{
        10'd25, 10'd50, 10'd100, 10'd150, 10'd200, 10'd250, 10'd300, 10'd350,
        10'd400, 10'd450, 10'd500, 10'd600, 10'd700, 10'd800, 10'd1000, 10'd1000};

    // Modulation index threshold in percent per code.
    localparam logic [6:0] PCR_MOD_PCT [8] = '{
        7'd0, 7'd40, 7'd50, 7'd60, 7'd70, 7'd80, 7'd90, 7'd100};

    // Digital speed input range limits in Hz.
    localparam logic [16:0] PCR_RANGE_HI_MIN = 17'd325;
    localparam logic [16:0] PCR_RANGE_HI_MAX = 17'd95000;
    localparam logic [16:0] PCR_RANGE_LO_MIN = 17'd10;
    localparam logic [16:0] PCR_RANGE_LO_MAX = 17'd325;

    // Power-up self-check sequencing states.
    typedef enum logic [2:0] {
        PCR_ST_IDLE = 3'b001,
        PCR_ST_CHECK = 3'b010,
        PCR_ST_DONE = 3'b100
    } pcr_boot_e;

endpackage

/* pcr_dir_select.sv */
// Direction selection and direction-change response for the motor controller.
// Assumes the direction pin has already passed a two flip-flop synchroniser.
`timescale 1ns/100ps
module pcr_dir_select
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] dir_override,
    input wire logic dir_change_mode,
    // Direction pin, synchronised
    input wire logic dir_pin_sync,
    // Results
    output logic dir_ccw,
    output logic dir_change_stop,
    output logic dir_change_reverse
);

    logic dir_now;
    logic dir_reg;
    logic [2:0] seen_reg;

    always_comb begin
        case (dir_override)
            PCR_DIR_FORCE_CW: dir_now = 1'b0;
            PCR_DIR_FORCE_CCW: dir_now = 1'b1;
            default: dir_now = dir_pin_sync;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_reg <= 1'b0;
            seen_reg <= 3'h0;
        end else begin
            dir_reg <= dir_now;
            seen_reg <= {seen_reg[1:0], 1'b1};
        end
    end

    // The pin synchroniser restarts from zero, so the stored direction is real only three edges after reset.
    // Comparing earlier would raise a false change pulse whenever the pin sits high through reset.
    wire dir_changed = seen_reg[2] && (dir_reg != dir_now);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_ccw <= 1'b0;
            dir_change_stop <= 1'b0;
            dir_change_reverse <= 1'b0;
        end else begin
            dir_ccw <= dir_now;
            dir_change_stop <= dir_changed && !dir_change_mode;
            dir_change_reverse <= dir_changed && dir_change_mode;
        end
    end

    property p_dir_forced;
        @(posedge clk_sys) disable iff (rst)
        (dir_override == PCR_DIR_FORCE_CW) |=> (dir_ccw == 1'b0);
    endproperty
    a_dir_forced: assert property (p_dir_forced) else $error("forced clockwise not applied");

    property p_dir_pin;
        @(posedge clk_sys) disable iff (rst)
        (dir_override == PCR_DIR_PIN_A || dir_override == PCR_DIR_PIN_B) |=> (dir_ccw == $past(dir_pin_sync));
    endproperty
    a_dir_pin: assert property (p_dir_pin) else $error("pin direction not followed");

    property p_dir_change;
        @(posedge clk_sys) disable iff (rst)
        dir_changed |=> (dir_change_reverse == $past(dir_change_mode)) && (dir_change_stop != dir_change_reverse);
    endproperty
    a_dir_change: assert property (p_dir_change) else $error("direction change response wrong");

endmodule

/* pcr_boot_check.sv */
// Power-up self-check sequencer: runs the check once after reset when enabled.
// Assumes the self-check engine answers with a one-cycle done pulse.
`timescale 1ns/100ps
module pcr_boot_check
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire logic selfchk_enable,
    // Self-check engine
    input wire logic selfchk_done,
    output logic selfchk_start,
    output logic boot_ready
);

    pcr_boot_e state_reg;
    logic settled_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= PCR_ST_IDLE;
        end else begin
            case (state_reg)
                PCR_ST_IDLE: begin
                    // The enable is sampled one cycle after release, so a reset value is used.
                    if (selfchk_enable) begin
                        state_reg <= PCR_ST_CHECK;
                    end else begin
                        state_reg <= PCR_ST_DONE;
                    end
                end
                PCR_ST_CHECK: begin
                    if (selfchk_done) begin
                        state_reg <= PCR_ST_DONE;
                    end
                end
                PCR_ST_DONE: state_reg <= PCR_ST_DONE;
                default: state_reg <= PCR_ST_IDLE;
            endcase
        end
    end

    // The machine still sits in reset at the releasing edge, so checks on its moves start one edge later.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            settled_reg <= 1'b0;
        end else begin
            settled_reg <= 1'b1;
        end
    end

    assign selfchk_start = (state_reg == PCR_ST_CHECK);
    assign boot_ready = (state_reg == PCR_ST_DONE);

    property p_skip;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        (state_reg == PCR_ST_IDLE && !selfchk_enable) |=> boot_ready && !selfchk_start;
    endproperty
    a_skip: assert property (p_skip) else $error("self-check not skipped");

    property p_run;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        (state_reg == PCR_ST_IDLE && selfchk_enable) |=> selfchk_start;
    endproperty
    a_run: assert property (p_run) else $error("self-check not started");

endmodule

/* pcr_top.sv */
// Peripheral configuration register with APB access and decoded settings.
// Assumes an APB master on clk_sys; the direction pin is asynchronous.
`timescale 1ns/100ps
module pcr_top
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic dir_pin,
    input wire logic alarm_request,
    output logic alarm_out,
    output logic alarm_out_oe_n,
    // Self-check engine
    input wire logic selfchk_done,
    output logic selfchk_start,
    // Decoded settings to the control core
    output logic spread_clock_modulation,
    output logic [15:0] bus_ilim_ma,
    output logic bus_ilim_active,
    output logic dir_ccw,
    output logic dir_change_stop,
    output logic dir_change_reverse,
    output logic [9:0] brake_gap_permille,
    output logic [6:0] brake_mod_pct,
    output logic [16:0] speed_in_min_hz,
    output logic [16:0] speed_in_max_hz,
    output logic boot_ready
);

    logic [31:0] config_reg;
    logic [31:0] config_next;
    logic [1:0] dir_sync_reg;
    logic [1:0] alarm_sync_reg;
    logic settled_reg;

    // Field views of the stored register.
    wire ss_modulation_off = config_reg[PCR_POS_SS_OFF];
    wire [3:0] ilim_code = config_reg[PCR_POS_ILIM_LO +: 4];
    wire ilim_enable = config_reg[PCR_POS_ILIM_EN];
    wire [1:0] dir_override = config_reg[PCR_POS_DIR_LO +: 2];
    wire dir_change_mode = config_reg[PCR_POS_DIR_MODE];
    wire selfchk_enable = config_reg[PCR_POS_SELFCHK];
    wire [3:0] brake_speed_gap_threshold = config_reg[PCR_POS_GAP_LO +: 4];
    wire [2:0] brake_modulation_threshold = config_reg[PCR_POS_MOD_LO +: 3];
    wire range_low = config_reg[PCR_POS_RANGE];
    wire alarm_output_off = config_reg[PCR_POS_ALARM_OFF];

    // APB decode. The slave answers in the first access cycle, no wait states.
    wire apb_access = psel && penable;
    wire hit_config = (paddr == PCR_ADDR_CONFIG_ONE);
    wire hit_status = (paddr == PCR_ADDR_STATUS);
    wire apb_write_cfg = apb_access && pwrite && hit_config;

    assign pready = 1'b1;
    assign pslverr = apb_access && !(hit_config || (hit_status && !pwrite));

    // Byte lanes merge into the stored word; reserved bits store like any other.
    always_comb begin
        config_next = config_reg;
        for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) begin
                config_next[i*8 +: 8] = pwdata[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            config_reg <= PCR_RESET_CONFIG_ONE;
        end else if (apb_write_cfg) begin
            config_reg <= config_next;
        end
    end

    // Read data is registered during setup so it stands through the access cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_config) begin
                prdata <= config_reg;
            end else if (hit_status) begin
                prdata <= {26'h0000000, dir_change_reverse, dir_change_stop, bus_ilim_active,
                           spread_clock_modulation, selfchk_start, boot_ready};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Pin synchronisers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_sync_reg <= 2'h0;
            alarm_sync_reg <= 2'h0;
        end else begin
            dir_sync_reg <= {dir_sync_reg[0], dir_pin};
            alarm_sync_reg <= {alarm_sync_reg[0], alarm_request};
        end
    end

    // Decoded settings are registered so the core sees clean levels.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            spread_clock_modulation <= 1'b0;
            bus_ilim_ma <= 16'h0000;
            bus_ilim_active <= 1'b0;
            brake_gap_permille <= 10'h000;
            brake_mod_pct <= 7'h00;
            speed_in_min_hz <= 17'h00000;
            speed_in_max_hz <= 17'h00000;
            alarm_out <= 1'b0;
            alarm_out_oe_n <= 1'b1;
        end else begin
            spread_clock_modulation <= !ss_modulation_off;
            bus_ilim_ma <= PCR_ILIM_MA[ilim_code];
            bus_ilim_active <= ilim_enable;
            if (brake_speed_gap_threshold == PCR_GAP_RESERVED) begin
                brake_gap_permille <= PCR_GAP_PERMILLE[PCR_GAP_FULL];
            end else begin
                brake_gap_permille <= PCR_GAP_PERMILLE[brake_speed_gap_threshold];
            end
            brake_mod_pct <= PCR_MOD_PCT[brake_modulation_threshold];
            speed_in_min_hz <= range_low ? PCR_RANGE_LO_MIN : PCR_RANGE_HI_MIN;
            speed_in_max_hz <= range_low ? PCR_RANGE_LO_MAX : PCR_RANGE_HI_MAX;
            // A disabled alarm pin is released, not driven low.
            alarm_out <= alarm_sync_reg[1] && !alarm_output_off;
            alarm_out_oe_n <= alarm_output_off;
        end
    end

    pcr_dir_select u_dir (
        .clk_sys(clk_sys),
        .rst(rst),
        .dir_override(dir_override),
        .dir_change_mode(dir_change_mode),
        .dir_pin_sync(dir_sync_reg[1]),
        .dir_ccw(dir_ccw),
        .dir_change_stop(dir_change_stop),
        .dir_change_reverse(dir_change_reverse)
    );

    pcr_boot_check u_boot (
        .clk_sys(clk_sys),
        .rst(rst),
        .selfchk_enable(selfchk_enable),
        .selfchk_done(selfchk_done),
        .selfchk_start(selfchk_start),
        .boot_ready(boot_ready)
    );

    // Decoded outputs still hold reset values after the releasing edge, so checks on them start one edge later.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            settled_reg <= 1'b0;
        end else begin
            settled_reg <= 1'b1;
        end
    end

    property p_ssm;
        @(posedge clk_sys) disable iff (rst)
        ##1 (spread_clock_modulation == !$past(ss_modulation_off));
    endproperty
    a_ssm: assert property (p_ssm) else $error("spread modulation does not follow bit");

    property p_ilim_code;
        @(posedge clk_sys) disable iff (rst)
        (ilim_code == 4'hE) |=> (bus_ilim_ma == 16'd7000);
    endproperty
    a_ilim_code: assert property (p_ilim_code) else $error("current limit code E wrong");

    property p_ilim_en;
        @(posedge clk_sys) disable iff (rst)
        !ilim_enable |=> !bus_ilim_active;
    endproperty
    a_ilim_en: assert property (p_ilim_en) else $error("current limit active while disabled");

    sequence s_write_gap_e;
        apb_write_cfg && pstrb[1] && pstrb[2] && (config_next[PCR_POS_GAP_LO +: 4] == PCR_GAP_RESERVED);
    endsequence
    sequence s_gap_full;
        ##2 (brake_gap_permille == 10'd1000);
    endsequence
    property p_gap_reserved;
        @(posedge clk_sys) disable iff (rst)
        s_write_gap_e |-> s_gap_full;
    endproperty
    a_gap_reserved: assert property (p_gap_reserved) else $error("reserved gap code not full");

    property p_gap_low;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        (brake_speed_gap_threshold == 4'h0) |=> (brake_gap_permille == 10'd25);
    endproperty
    a_gap_low: assert property (p_gap_low) else $error("gap code 0 wrong");

    property p_mod;
        @(posedge clk_sys) disable iff (rst)
        (brake_modulation_threshold == 3'h1) |=> (brake_mod_pct == 7'd40);
    endproperty
    a_mod: assert property (p_mod) else $error("modulation code 1 wrong");

    property p_range;
        @(posedge clk_sys) disable iff (rst)
        range_low |=> (speed_in_min_hz == 17'd10) && (speed_in_max_hz == 17'd325);
    endproperty
    a_range: assert property (p_range) else $error("low speed range wrong");

    property p_alarm;
        @(posedge clk_sys) disable iff (rst)
        alarm_output_off |=> alarm_out_oe_n && !alarm_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm pin not disabled");

    property p_write_full;
        @(posedge clk_sys) disable iff (rst)
        apb_write_cfg && (pstrb == 4'hF) |=> (config_reg == $past(pwdata));
    endproperty
    a_write_full: assert property (p_write_full) else $error("full-word write not stored");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        !apb_write_cfg |=> $stable(config_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without a write");

    property p_err_unmapped;
        @(posedge clk_sys) disable iff (rst)
        apb_access && !hit_config && !hit_status |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_err_status_write;
        @(posedge clk_sys) disable iff (rst)
        apb_access && pwrite && hit_status |-> pslverr;
    endproperty
    a_err_status_write: assert property (p_err_status_write) else $error("status write not refused");

    property p_cfg_ok;
        @(posedge clk_sys) disable iff (rst)
        apb_access && hit_config |-> !pslverr;
    endproperty
    a_cfg_ok: assert property (p_cfg_ok) else $error("config access refused");

    property p_read_cfg;
        @(posedge clk_sys) disable iff (rst)
        psel && !penable && !pwrite && hit_config |=> (prdata == $past(config_reg));
    endproperty
    a_read_cfg: assert property (p_read_cfg) else $error("config read data wrong");

    property p_read_unmapped;
        @(posedge clk_sys) disable iff (rst)
        psel && !penable && !pwrite && !hit_config && !hit_status |=> (prdata == 32'h00000000);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read data not zero");

    property p_ilim_low;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        (ilim_code == 4'h0) |=> (bus_ilim_ma == 16'd125);
    endproperty
    a_ilim_low: assert property (p_ilim_low) else $error("current limit code 0 wrong");

    property p_ilim_top;
        @(posedge clk_sys) disable iff (rst)
        (ilim_code == 4'hF) |=> (bus_ilim_ma == 16'd8000);
    endproperty
    a_ilim_top: assert property (p_ilim_top) else $error("current limit code F wrong");

    property p_ilim_on;
        @(posedge clk_sys) disable iff (rst)
        ilim_enable |=> bus_ilim_active;
    endproperty
    a_ilim_on: assert property (p_ilim_on) else $error("current limit not active while enabled");

    property p_gap_top;
        @(posedge clk_sys) disable iff (rst)
        (brake_speed_gap_threshold == 4'hD) |=> (brake_gap_permille == 10'd800);
    endproperty
    a_gap_top: assert property (p_gap_top) else $error("gap code D wrong");

    property p_mod_zero;
        @(posedge clk_sys) disable iff (rst)
        (brake_modulation_threshold == 3'h0) |=> (brake_mod_pct == 7'd0);
    endproperty
    a_mod_zero: assert property (p_mod_zero) else $error("modulation code 0 wrong");

    property p_range_high;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        !range_low |=> (speed_in_min_hz == 17'd325) && (speed_in_max_hz == 17'd95000);
    endproperty
    a_range_high: assert property (p_range_high) else $error("high speed range wrong");

    property p_alarm_on;
        @(posedge clk_sys) disable iff (rst || !settled_reg)
        !alarm_output_off |=> !alarm_out_oe_n && (alarm_out == $past(alarm_sync_reg[1]));
    endproperty
    a_alarm_on: assert property (p_alarm_on) else $error("enabled alarm pin not following request");

endmodule

/* test_peripheral_config_register.sv */
// Self-checking testbench for the peripheral configuration register block.
// Assumes pcr_top with zero-wait APB and decoded outputs one cycle behind the register.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_peripheral_config_register;
    import pcr_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dir_pin = 1'b0;
    logic alarm_request = 1'b1;
    logic alarm_out;
    logic alarm_out_oe_n;
    logic selfchk_done = 1'b0;
    logic selfchk_start;
    logic spread_clock_modulation;
    logic [15:0] bus_ilim_ma;
    logic bus_ilim_active;
    logic dir_ccw;
    logic dir_change_stop;
    logic dir_change_reverse;
    logic [9:0] brake_gap_permille;
    logic [6:0] brake_mod_pct;
    logic [16:0] speed_in_min_hz;
    logic [16:0] speed_in_max_hz;
    logic boot_ready;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int stop_seen = 0;
    int rev_seen = 0;
    logic [31:0] rd;
    logic er;
    logic [31:0] v;
    logic [3:0] c;

    pcr_top dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dir_pin(dir_pin), .alarm_request(alarm_request), .alarm_out(alarm_out),
        .alarm_out_oe_n(alarm_out_oe_n), .selfchk_done(selfchk_done), .selfchk_start(selfchk_start),
        .spread_clock_modulation(spread_clock_modulation), .bus_ilim_ma(bus_ilim_ma),
        .bus_ilim_active(bus_ilim_active), .dir_ccw(dir_ccw), .dir_change_stop(dir_change_stop),
        .dir_change_reverse(dir_change_reverse), .brake_gap_permille(brake_gap_permille),
        .brake_mod_pct(brake_mod_pct), .speed_in_min_hz(speed_in_min_hz),
        .speed_in_max_hz(speed_in_max_hz), .boot_ready(boot_ready)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic wrap_up();
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The ceiling leaves ample margin over the few hundred cycles the sequence needs.
    // Pulses are counted mid-cycle, away from the edge that launches them.
    always @(negedge clk_sys) begin
        if (dir_change_stop === 1'b1) stop_seen++;
        if (dir_change_reverse === 1'b1) rev_seen++;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // One APB transfer; called right after a rising edge, returns one edge after release.
    // A hung slave is caught only by the run's cycle ceiling.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic cfg(input logic [31:0] d);
        apb(1'b1, PCR_ADDR_CONFIG_ONE, d, 4'hF);
        repeat (3) @(posedge clk_sys);
    endtask

    function automatic logic [15:0] ilim_exp(input logic [3:0] k);
        if (k < 4'h4) return 16'h007D << k;
        if (k == 4'hE) return 16'h1B58;
        if (k == 4'hF) return 16'h1F40;
        return 16'h05DC + 16'(k - 4'h4) * 16'h01F4;
    endfunction

    function automatic logic [9:0] gap_exp(input logic [3:0] k);
        case (k)
            4'h0: return 10'h019;
            4'h1: return 10'h032;
            4'h2: return 10'h064;
            4'hB: return 10'h258;
            4'hC: return 10'h2BC;
            4'hD: return 10'h320;
            4'hE, 4'hF: return 10'h3E8;
            default: return 10'h096 + 10'(k - 4'h3) * 10'h032;
        endcase
    endfunction

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, PCR_ADDR_CONFIG_ONE, 32'h00000000, 4'hF);
        `CHK(rd, PCR_RESET_CONFIG_ONE)
        `CHK(spread_clock_modulation, 1'b0)
        `CHK(selfchk_start, 1'b0)
        `CHK(boot_ready, 1'b1)
        selfchk_done <= 1'b1;
        @(posedge clk_sys);
        selfchk_done <= 1'b0;
        apb(1'b0, PCR_ADDR_STATUS, 32'h00000000, 4'hF);
        `CHK({rd[1:0], er}, 3'b010)
        // Only the low byte lane is strobed, so the set modulation-off bit must survive.
        apb(1'b1, PCR_ADDR_CONFIG_ONE, 32'h000000FF, 4'h1);
        apb(1'b0, PCR_ADDR_CONFIG_ONE, 32'h00000000, 4'hF);
        `CHK(rd, 32'h400000FF)
        apb(1'b1, PCR_ADDR_STATUS, 32'hFFFFFFFF, 4'hF);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h000, 32'h00000000, 4'hF);
        `CHK({rd, er}, {32'h00000000, 1'b1})
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            v = (32'(c) << PCR_POS_ILIM_LO) | (32'(c) << PCR_POS_GAP_LO) | (32'(c[2:0]) << PCR_POS_MOD_LO) |
                (32'(c[0]) << PCR_POS_ILIM_EN) | (32'(c[0]) << PCR_POS_SS_OFF) |
                (32'(c[1]) << PCR_POS_RANGE) | (32'(c[2]) << PCR_POS_ALARM_OFF);
            cfg(v);
            apb(1'b0, PCR_ADDR_CONFIG_ONE, 32'h00000000, 4'hF);
            `CHK(rd, v)
            `CHK(spread_clock_modulation, ~c[0])
            `CHK(bus_ilim_ma, ilim_exp(c))
            `CHK(bus_ilim_active, c[0])
            `CHK(brake_gap_permille, gap_exp(c))
            `CHK(brake_mod_pct, (c[2:0] == 3'h0) ? 7'h00 : 7'h28 + 7'(c[2:0] - 3'h1) * 7'h0A)
            `CHK(speed_in_min_hz, c[1] ? 17'h0000A : 17'h00145)
            `CHK(speed_in_max_hz, c[1] ? 17'h00145 : 17'h17318)
            `CHK(alarm_out_oe_n, c[2])
            `CHK(alarm_out, ~c[2])
        end
        for (int k = 0; k < 8; k++) begin
            cfg(32'(k[2:1]) << PCR_POS_DIR_LO);
            dir_pin <= k[0];
            repeat (6) @(posedge clk_sys);
            `CHK(dir_ccw, (k[2:1] == 2'h1) ? 1'b0 : (k[2:1] == 2'h2) ? 1'b1 : k[0])
        end
        // Each mode must answer a pin flip with exactly one pulse of its own kind.
        for (int m = 0; m < 2; m++) begin
            cfg(32'(m) << PCR_POS_DIR_MODE);
            repeat (6) @(posedge clk_sys);
            stop_seen = 0;
            rev_seen = 0;
            dir_pin <= ~dir_pin;
            repeat (10) @(posedge clk_sys);
            `CHK({stop_seen, rev_seen}, (m == 0) ? {32'd1, 32'd0} : {32'd0, 32'd1})
        end
        // The enabled alarm pin follows its request level.
        `CHK(alarm_out, 1'b1)
        alarm_request <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK(alarm_out, 1'b0)
        // A mid-run reset with the pin high must restore the register and raise no change pulse.
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        stop_seen = 0;
        rev_seen = 0;
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        `CHK({stop_seen, rev_seen}, {32'd0, 32'd0})
        apb(1'b0, PCR_ADDR_CONFIG_ONE, 32'h00000000, 4'hF);
        `CHK(rd, PCR_RESET_CONFIG_ONE)
        `CHK({spread_clock_modulation, boot_ready, alarm_out_oe_n}, 3'b010)
        wrap_up();
    end
endmodule
